/* File: rpttl_regs.vh */
/*
  constants for the rear panel ttl trigger/limit/user line block: register offsets,
  field positions, reset values and timing counts.
  assumes inclusion by bare name from every file that needs them.
*/
`ifndef RPTTL_REGS_VH
`define RPTTL_REGS_VH

// register offsets (word index on the plain register port)
`define RPTTL_ADDR_W          4
`define RPTTL_OFF_CTRL        4'h0
`define RPTTL_OFF_STATUS      4'h1
`define RPTTL_OFF_IRQ_STAT    4'h2
`define RPTTL_OFF_IRQ_MASK    4'h3
`define RPTTL_OFF_LIMIT       4'h4
`define RPTTL_DATA_W          16

// control register fields
`define RPTTL_CTRL_TRIG_EN    0
`define RPTTL_CTRL_TRIG_PT    1
`define RPTTL_CTRL_LIM_EN1    2
`define RPTTL_CTRL_LIM_EN2    3
`define RPTTL_CTRL_LIM_BIT    4
`define RPTTL_CTRL_USR_BIT    5
`define RPTTL_CTRL_USR_LO     6
`define RPTTL_CTRL_USR_HI     7
`define RPTTL_CTRL_RESET      16'h0000

// user line modes
`define RPTTL_USR_SWBIT       2'h0
`define RPTTL_USR_SWITCH      2'h1
`define RPTTL_USR_SWEEP       2'h2

// limit register fields: latched pass result per channel
`define RPTTL_LIM_PASS1       0
`define RPTTL_LIM_PASS2       1

// interrupt event bits
`define RPTTL_IRQ_TRIG        0
`define RPTTL_IRQ_POINT       1
`define RPTTL_IRQ_KEY         2
`define RPTTL_IRQ_FAIL        3
`define RPTTL_IRQ_W           4

// timing: point pulse width in ns and in 8 ns cycles (1000 ns / 8 ns = 125)
`define RPTTL_CLK_NS          8
`define RPTTL_PULSE_NS        1000
`define RPTTL_PULSE_CYC       8'h7D
`define RPTTL_PCNT_W          8

`endif

/* File: rpttl_sync.v */
/*
  two-flop synchroniser for the incoming rear panel line levels.
  assumes mclk domain and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rpttl_sync #(
  parameter W = 3
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  // pins idle high (open collector with pull-up)
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // rpttl_sync
`default_nettype wire

/* File: rpttl_top.v */
/*
  rear panel ttl lines: external trigger in/out, limit result, user line.
  assumes: lines are open collector with external pull-ups; the sweep engine gives
  sweep_active and point_done; the limit engine gives per-channel results.
*/
// The strobed register port and the placing of the registers are this design's own decisions.
// Function
// - a rising edge on the trigger line starts a sweep or a point step, as selected.
// - while the trigger line is low no triggered sweep or step starts.
// - during a sweep a short low pulse is driven per measured point.
// - the limit line is released high on pass and pulled low on fail.
// - each of the two channels has its own limit test enable.
// - with both enabled, high only when both channels pass.
// - with both disabled, the limit line is a software bit.
// - the user line has three uses, default a software bit.
// - in switch mode a closure on the user line acts as a key press.
// - in sweep mode the user line is high during a sweep, low otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "rpttl_regs.vh"
module rpttl_top (
  input  wire                     mclk,
  input  wire                     rst_n,
  input  wire [`RPTTL_ADDR_W-1:0] reg_addr,
  input  wire [`RPTTL_DATA_W-1:0] reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`RPTTL_DATA_W-1:0] reg_rdata,
  output reg                      irq,
  input  wire                     sweep_active,
  input  wire                     point_done,
  input  wire                     lim_valid,
  input  wire                     lim_pass1,
  input  wire                     lim_pass2,
  output reg                      trig_sweep,
  output reg                      trig_point,
  output reg                      key_press,
  input  wire                     trig_i,
  output reg                      trig_o,
  output reg                      trig_oe,
  input  wire                     lim_i,
  output reg                      lim_o,
  output reg                      lim_oe,
  input  wire                     usr_i,
  output reg                      usr_o,
  output reg                      usr_oe
);
  reg  [`RPTTL_DATA_W-1:0] ctrl_r;
  reg  [`RPTTL_IRQ_W-1:0]  irq_stat_r;
  reg  [`RPTTL_IRQ_W-1:0]  irq_mask_r;
  reg  [1:0]               pass_r;
  reg  [`RPTTL_PCNT_W-1:0] pcnt_r;
  reg                      trig_prev_r;
  reg                      usr_prev_r;
  reg                      pulse_on_r;
  reg  [2:0]               own_r;
  wire [2:0]               sync_q;
  wire                     trig_s;
  wire                     lim_s;
  wire                     usr_s;
  wire [1:0]               usr_mode;
  wire                     en1;
  wire                     en2;
  reg                      lim_level;
  reg                      usr_level;
  reg                      trig_rise;
  reg                      key_fall;
  reg  [`RPTTL_IRQ_W-1:0]  ev;
  reg  [`RPTTL_DATA_W-1:0] rd_mux;

  rpttl_sync #(
    .W (3)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({usr_i, lim_i, trig_i}),
    .q     (sync_q)
  );

  assign trig_s   = sync_q[0];
  assign lim_s    = sync_q[1];
  assign usr_s    = sync_q[2];
  assign usr_mode = ctrl_r[`RPTTL_CTRL_USR_HI:`RPTTL_CTRL_USR_LO];
  assign en1      = ctrl_r[`RPTTL_CTRL_LIM_EN1];
  assign en2      = ctrl_r[`RPTTL_CTRL_LIM_EN2];

  always @* begin
    // start on rising edge; our own point pulse is masked out
    // own_r covers the synchroniser delay after our pulse ends, so the release is no start
    trig_rise = trig_s & ~trig_prev_r & ctrl_r[`RPTTL_CTRL_TRIG_EN] & ~pulse_on_r
                & ~(|own_r);
    // closure pulls the line low; edge stands in for a key press
    key_fall  = (usr_mode == `RPTTL_USR_SWITCH) & ~usr_s & usr_prev_r;
    // per-channel enables select the limit source
    case ({en2, en1})
      2'b00: lim_level = ctrl_r[`RPTTL_CTRL_LIM_BIT];
      2'b01: lim_level = pass_r[0];
      2'b10: lim_level = pass_r[1];
      2'b11: lim_level = pass_r[0] & pass_r[1];
      default: lim_level = 1'b1;
    endcase
    case (usr_mode)
      `RPTTL_USR_SWBIT:  usr_level = ctrl_r[`RPTTL_CTRL_USR_BIT];
      `RPTTL_USR_SWITCH: usr_level = 1'b1;
      `RPTTL_USR_SWEEP:  usr_level = sweep_active;
      default:           usr_level = ctrl_r[`RPTTL_CTRL_USR_BIT];
    endcase
    ev                       = {`RPTTL_IRQ_W{1'b0}};
    ev[`RPTTL_IRQ_TRIG]      = trig_rise;
    ev[`RPTTL_IRQ_POINT]     = point_done & sweep_active;
    ev[`RPTTL_IRQ_KEY]       = key_fall;
    ev[`RPTTL_IRQ_FAIL]      = lim_valid & ~(lim_pass1 & lim_pass2);
    case (reg_addr)
      `RPTTL_OFF_CTRL:     rd_mux = ctrl_r;
      `RPTTL_OFF_STATUS:   rd_mux = {11'h000, sweep_active, pulse_on_r, usr_s, lim_s, trig_s};
      `RPTTL_OFF_IRQ_STAT: rd_mux = {12'h000, irq_stat_r};
      `RPTTL_OFF_IRQ_MASK: rd_mux = {12'h000, irq_mask_r};
      `RPTTL_OFF_LIMIT:    rd_mux = {14'h0000, pass_r};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r      <= `RPTTL_CTRL_RESET;
      irq_stat_r  <= {`RPTTL_IRQ_W{1'b0}};
      irq_mask_r  <= {`RPTTL_IRQ_W{1'b0}};
      pass_r      <= 2'b11;
      pcnt_r      <= {`RPTTL_PCNT_W{1'b0}};
      pulse_on_r  <= 1'b0;
      own_r       <= 3'h0;
      trig_prev_r <= 1'b1;
      usr_prev_r  <= 1'b1;
      reg_rdata   <= 16'h0000;
      irq         <= 1'b0;
      trig_sweep  <= 1'b0;
      trig_point  <= 1'b0;
      key_press   <= 1'b0;
      trig_o      <= 1'b0;
      trig_oe     <= 1'b0;
      lim_o       <= 1'b0;
      lim_oe      <= 1'b0;
      usr_o       <= 1'b0;
      usr_oe      <= 1'b0;
    end else begin
      trig_prev_r <= trig_s;
      usr_prev_r  <= usr_s;
      own_r       <= {own_r[1:0], trig_oe};
      if (reg_wr && reg_addr == `RPTTL_OFF_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `RPTTL_OFF_IRQ_MASK) begin
        irq_mask_r <= reg_wdata[`RPTTL_IRQ_W-1:0];
      end
      // write one to clear; a new event in the same cycle wins
      if (reg_wr && reg_addr == `RPTTL_OFF_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata[`RPTTL_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
      irq       <= |((irq_stat_r | ev) & irq_mask_r);
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      if (lim_valid) begin
        pass_r <= {lim_pass2, lim_pass1};
      end
      // a held-low line never yields a start
      trig_sweep <= trig_rise & ~ctrl_r[`RPTTL_CTRL_TRIG_PT];
      trig_point <= trig_rise & ctrl_r[`RPTTL_CTRL_TRIG_PT];
      key_press  <= key_fall;
      // low pulse per measured point; retriggers extend it
      if (point_done && sweep_active) begin
        pcnt_r     <= `RPTTL_PULSE_CYC;
        pulse_on_r <= 1'b1;
      end else if (pcnt_r != {`RPTTL_PCNT_W{1'b0}}) begin
        pcnt_r     <= pcnt_r - 1'b1;
        pulse_on_r <= (pcnt_r != {{(`RPTTL_PCNT_W-1){1'b0}}, 1'b1});
      end else begin
        pulse_on_r <= 1'b0;
      end
      // open collector: only ever drive low, release for high
      trig_o  <= 1'b0;
      trig_oe <= (point_done & sweep_active) | (pcnt_r > {{(`RPTTL_PCNT_W-1){1'b0}}, 1'b1});
      // release on pass, pull low on fail
      lim_o   <= 1'b0;
      lim_oe  <= ~lim_level;
      usr_o   <= 1'b0;
      usr_oe  <= ~usr_level;
    end
  end
endmodule // rpttl_top
`default_nettype wire

/* File: rpttl_top_assertions.sv */
/* checker for rpttl_top, bound from the foot of this file.
   assumes one clock, mclk, and the register map of rpttl_regs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "rpttl_regs.vh"
module rpttl_chk (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic [`RPTTL_ADDR_W-1:0] reg_addr,
  input wire logic [`RPTTL_DATA_W-1:0] reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     sweep_active,
  input wire logic                     point_done,
  input wire logic                     lim_valid,
  input wire logic                     lim_pass1,
  input wire logic                     lim_pass2,
  input wire logic                     trig_sweep,
  input wire logic                     trig_point,
  input wire logic                     key_press,
  input wire logic                     trig_i,
  input wire logic                     trig_oe,
  input wire logic                     lim_oe,
  input wire logic                     usr_i,
  input wire logic                     usr_oe
);
  reg  [7:0] c_r;
  reg        p1_r;
  reg        p2_r;
  // shadow of control and latched results, seen only through the ports
  wire       lvl = c_r[3:2] == 2'h0 ? c_r[4] : c_r[3:2] == 2'h1 ? p1_r : p2_r;
  always @(posedge mclk) begin
    if (!rst_n) begin
      c_r <= 8'h00;
      p1_r <= 1'b1;
      p2_r <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == `RPTTL_OFF_CTRL) c_r <= reg_wdata[7:0];
      if (lim_valid) p1_r <= lim_pass1;
      if (lim_valid) p2_r <= lim_pass2;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_trig_quiet; !trig_i [*4] |-> !(trig_sweep || trig_point); endproperty
  a_trig_quiet: assert property (p_trig_quiet)
    else $error("start while trigger line low");
  property p_trig_cause; (trig_sweep || trig_point) |-> $past(trig_i, 3); endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("start without synchronised high line");
  property p_pt_pulse; point_done && sweep_active |=> trig_oe [*8]; endproperty
  a_pt_pulse: assert property (p_pt_pulse)
    else $error("point pulse missing or short");
  property p_lim_and; $past(rst_n) && $past(c_r[3:2]) == 2'h3 |->
    lim_oe == !($past(p1_r) && $past(p2_r)); endproperty
  a_lim_and: assert property (p_lim_and)
    else $error("limit line not the and of both channels");
  property p_lim_sel; $past(rst_n) && $past(c_r[3:2]) != 2'h3 |-> lim_oe != $past(lvl);
  endproperty
  a_lim_sel: assert property (p_lim_sel)
    else $error("limit line level wrong");
  property p_usr_bit; $past(rst_n) && $past(c_r[7:6]) == 2'h0 |-> usr_oe != $past(c_r[5]);
  endproperty
  a_usr_bit: assert property (p_usr_bit)
    else $error("user line not following software bit");
  property p_usr_key; key_press |-> !$past(usr_i, 3) && !usr_oe; endproperty
  a_usr_key: assert property (p_usr_key)
    else $error("key press without switch closure");
  property p_usr_swp; $past(rst_n) && $past(c_r[7:6]) == 2'h2 |->
    usr_oe != $past(sweep_active); endproperty
  a_usr_swp: assert property (p_usr_swp)
    else $error("user line not showing sweep");
  c_point: cover property (trig_point);
  c_key: cover property (key_press);
  c_pulse: cover property ($rose(trig_oe));
endmodule // rpttl_chk
bind rpttl_top rpttl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sweep_active(sweep_active),
  .point_done(point_done), .lim_valid(lim_valid), .lim_pass1(lim_pass1),
  .lim_pass2(lim_pass2), .trig_sweep(trig_sweep), .trig_point(trig_point),
  .key_press(key_press), .trig_i(trig_i), .trig_oe(trig_oe), .lim_oe(lim_oe),
  .usr_i(usr_i), .usr_oe(usr_oe));
`default_nettype wire

/* File: rpttl_far.sv */
/* far side of the rear panel lines: pull-ups plus external pull-down drivers.
   assumes the bench commands each pull. */
`timescale 1ns/1ps
`default_nettype none
module rpttl_far (
  input  wire logic trig_oe,
  input  wire logic lim_oe,
  input  wire logic usr_oe,
  input  wire logic trig_pull,
  input  wire logic lim_pull,
  input  wire logic usr_pull,
  output wire logic trig_i,
  output wire logic lim_i,
  output wire logic usr_i
);
  assign trig_i = !(trig_oe || trig_pull);
  assign lim_i = !(lim_oe || lim_pull);
  assign usr_i = !(usr_oe || usr_pull);
endmodule // rpttl_far
`default_nettype wire

/* File: tb.sv */
/* bench for rpttl_top: register tasks and line checks.
   assumes rpttl_far on the lines and an 8 ns mclk. */
`timescale 1ns/1ps
`default_nettype none
`include "rpttl_regs.vh"
module tb;
  reg         mclk, rst_n, reg_wr, reg_rd, sweep_active, point_done, lim_valid;
  reg         lim_pass1, lim_pass2, tp, lp, up, e;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata, d;
  reg  [2:0]  cap;
  wire [15:0] reg_rdata;
  wire        irq, trig_sweep, trig_point, key_press, trig_i, trig_oe, lim_i, lim_oe;
  wire        usr_i, usr_oe;
  integer     err_count, compares, i;
  rpttl_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .sweep_active(sweep_active), .point_done(point_done), .lim_valid(lim_valid),
    .lim_pass1(lim_pass1), .lim_pass2(lim_pass2), .trig_sweep(trig_sweep),
    .trig_point(trig_point), .key_press(key_press), .trig_i(trig_i), .trig_o(),
    .trig_oe(trig_oe), .lim_i(lim_i), .lim_o(), .lim_oe(lim_oe), .usr_i(usr_i),
    .usr_o(), .usr_oe(usr_oe));
  rpttl_far far (.trig_oe(trig_oe), .lim_oe(lim_oe), .usr_oe(usr_oe), .trig_pull(tp),
    .lim_pull(lp), .usr_pull(up), .trig_i(trig_i), .lim_i(lim_i), .usr_i(usr_i));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (trig_sweep || trig_point || key_press) cap <= {key_press, trig_point, trig_sweep};
  task summarize;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] x);
    compares = compares + 1;
    if (g !== x) begin
      err_count = err_count + 1;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input [3:0] a, input [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait for a captured event
  task wt;
    integer k;
    for (k = 0; k < 40 && cap == 3'h0; k = k + 1) @(posedge mclk);
    #1;
    if (cap == 3'h0) begin
      err_count = err_count + 1;
      summarize;
    end
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, sweep_active, point_done, lim_valid, lim_pass1, lim_pass2} = 8'h00;
    {tp, lp, up, reg_addr, reg_wdata, cap} = 26'h000_0000;
    err_count = 0;
    compares = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(2);
    rd(`RPTTL_OFF_CTRL);
    chk(d, `RPTTL_CTRL_RESET);
    chk(usr_i, 1'b0);
    rd(4'hF);
    chk(d, 16'h0000);
    wr(`RPTTL_OFF_IRQ_MASK, 16'h000F);
    for (i = 0; i < 32; i = i + 1) begin
      lim_pass1 <= i[0];
      lim_pass2 <= i[1];
      lim_valid <= 1'b1;
      wr(`RPTTL_OFF_CTRL, {11'h000, i[4:2], 2'h0});
      lim_valid <= 1'b0;
      e = i[3:2] == 2'h0 ? i[4] : i[3:2] == 2'h1 ? i[0] : i[3:2] == 2'h2 ? i[1] : i[0] & i[1];
      cyc(2);
      chk(lim_i, e);
      rd(`RPTTL_OFF_LIMIT);
      chk(d, {14'h0000, i[1:0]});
    end
    chk(irq, 1'b1);
    wr(`RPTTL_OFF_IRQ_STAT, 16'h000F);
    cyc(2);
    chk(irq, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`RPTTL_OFF_CTRL, {14'h0000, i[0], 1'b1});
      tp <= 1'b1;
      cap = 3'h0;
      cyc(8);
      chk(cap, 3'h0);
      tp <= 1'b0;
      wt;
      chk(cap, i[0] ? 3'h2 : 3'h1);
    end
    cap = 3'h0;
    sweep_active <= 1'b1;
    point_done <= 1'b1;
    cyc(1);
    point_done <= 1'b0;
    cyc(1);
    chk(trig_i, 1'b0);
    cyc(`RPTTL_PULSE_CYC);
    chk(trig_i, 1'b1);
    cyc(5);
    chk(cap, 3'h0);
    lp <= 1'b1;
    cyc(3);
    rd(`RPTTL_OFF_STATUS);
    chk(d[1], 1'b0);
    lp <= 1'b0;
    wr(`RPTTL_OFF_CTRL, 16'h0080);
    cyc(2);
    chk(usr_i, 1'b1);
    sweep_active <= 1'b0;
    cyc(2);
    chk(usr_i, 1'b0);
    wr(`RPTTL_OFF_CTRL, 16'h0020);
    cyc(2);
    chk(usr_i, 1'b1);
    wr(`RPTTL_OFF_IRQ_STAT, 16'h000F);
    wr(`RPTTL_OFF_CTRL, 16'h0040);
    cyc(3);
    cap = 3'h0;
    up <= 1'b1;
    wt;
    chk(cap, 3'h4);
    up <= 1'b0;
    cyc(2);
    chk(irq, 1'b1);
    wr(`RPTTL_OFF_IRQ_MASK, 16'h0000);
    cyc(2);
    chk(irq, 1'b0);
    rd(`RPTTL_OFF_IRQ_STAT);
    chk(d[2], 1'b1);
    summarize;
  end
endmodule // tb
`default_nettype wire
